// >>> pms_pkg.sv
package pms_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int          CLK_HZ         = 100_000_000;
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          RAMP_TICK_US   = 1000;
  localparam int          RAMP_TICK_CYC  = RAMP_TICK_US * 1000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // widths and limits
  // ----------------------------------------------------------------------
  localparam int          DATA_W         = 32;
  localparam int          SEL_W          = 8;
  localparam int          ADDR_W         = 11;
  localparam int          FLD_LSB        = 8;
  localparam int          ENTRIES        = 256;
  localparam logic [31:0] MAX_TRAVEL     = 32'h7fff_ffff;

  // ----------------------------------------------------------------------
  // register map: addr = {field, index}
  // ----------------------------------------------------------------------
  localparam logic [2:0]  FLD_POS        = 3'h0;
  localparam logic [2:0]  FLD_SPD        = 3'h1;
  localparam logic [2:0]  FLD_TYPE       = 3'h2;
  localparam logic [2:0]  FLD_GLOBAL     = 3'h4;
  localparam logic [7:0]  REG_START_SPD  = 8'h00;
  localparam logic [7:0]  REG_ACCEL      = 8'h01;
  localparam logic [7:0]  REG_WRAP_RANGE = 8'h02;
  localparam logic [7:0]  REG_CMD_POS    = 8'h03;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_WRAP_POS   = 8'h05;

  localparam int          ST_READY       = 0;
  localparam int          ST_MOVING      = 1;
  localparam int          ST_ALARM       = 2;

  localparam logic [31:0] START_SPD_RST  = 32'h0000_01f4;
  localparam logic [31:0] ACCEL_RST      = 32'h0000_0002;
  localparam logic [31:0] WRAP_RANGE_RST = 32'h0000_e100;

  typedef enum logic [1:0] {
    PMS_ABS      = 2'b00,
    PMS_INC_CMD  = 2'b01,
    PMS_INC_FB   = 2'b10,
    PMS_WRAP_ABS = 2'b11
  } pms_optype_e;

endpackage

// >>> pms_profile.sv
`timescale 1ns/1ns
module pms_profile
  import pms_pkg::*;
#(
  parameter int TICK_CYC = RAMP_TICK_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic [31:0] steps_i,
  input  wire logic [31:0] v_start_i,
  input  wire logic [31:0] v_run_i,
  input  wire logic [31:0] accel_i,
  output logic             step_o,
  output logic             busy_o,
  output logic             done_o
);

  // ----------------------------------------------------------------------
  // profile state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    P_IDLE  = 2'b00,
    P_ACCEL = 2'b01,
    P_HOLD  = 2'b10,
    P_DECEL = 2'b11
  } pms_pstate_e;

  pms_pstate_e state_reg;
  logic [31:0] remain_reg;
  logic [31:0] ramp_steps_reg;
  logic [31:0] speed_reg;
  logic [31:0] phase_reg;
  logic [31:0] tick_reg;

  wire  [32:0] phase_sum  = {1'b0, phase_reg} + {1'b0, speed_reg};
  wire         running    = (state_reg != P_IDLE);
  wire         step_hit   = running && (phase_sum >= 33'(CLK_HZ));
  wire         tick       = (tick_reg == 32'(TICK_CYC - 1));
  wire  [31:0] remain_nx  = remain_reg - 32'h0000_0001;
  wire         decel_due  = step_hit && (remain_nx <= ramp_steps_reg);
  wire  [32:0] spd_up     = {1'b0, speed_reg} + {1'b0, accel_i};
  wire  [32:0] spd_dn     = {1'b0, speed_reg} - {1'b0, accel_i};
  wire         at_run     = spd_up >= {1'b0, v_run_i};
  wire         at_floor   = spd_dn[32] || (spd_dn[31:0] <= v_start_i);

  // ----------------------------------------------------------------------
  // trapezoid: decel starts once what is left is no more than what the ramp used,
  // so no division is needed; the tail runs at start speed to land exactly
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg      <= P_IDLE;
      remain_reg     <= 32'h0000_0000;
      ramp_steps_reg <= 32'h0000_0000;
      speed_reg      <= 32'h0000_0000;
      phase_reg      <= 32'h0000_0000;
      tick_reg       <= 32'h0000_0000;
      step_o         <= 1'b0;
      done_o         <= 1'b0;
    end else begin
      step_o <= step_hit;
      done_o <= 1'b0;
      tick_reg <= (tick || !running) ? 32'h0000_0000 : tick_reg + 32'h1;
      if (step_hit) begin
        phase_reg  <= phase_sum[31:0] - 32'(CLK_HZ);
        remain_reg <= remain_nx;
      end else if (running) begin
        phase_reg <= phase_sum[31:0];
      end
      case (state_reg)
        P_IDLE: begin
          if (go_i && steps_i == 32'h0000_0000) begin
            done_o <= 1'b1;
          end else if (go_i) begin
            remain_reg     <= steps_i;
            ramp_steps_reg <= 32'h0000_0000;
            speed_reg      <= v_start_i;
            phase_reg      <= 32'h0000_0000;
            state_reg      <= P_ACCEL;
          end
        end
        P_ACCEL: begin
          if (step_hit) begin
            ramp_steps_reg <= ramp_steps_reg + 32'h1;
          end
          if (decel_due) begin
            state_reg <= P_DECEL;
          end else if (tick) begin
            speed_reg <= at_run ? v_run_i : spd_up[31:0];
            if (at_run) begin
              state_reg <= P_HOLD;
            end
          end
        end
        P_HOLD: begin
          if (decel_due) begin
            state_reg <= P_DECEL;
          end
        end
        P_DECEL: begin
          if (tick) begin
            speed_reg <= at_floor ? v_start_i : spd_dn[31:0];
          end
        end
        default: state_reg <= P_IDLE;
      endcase
      if (step_hit && remain_reg == 32'h0000_0001) begin
        state_reg <= P_IDLE;
        done_o    <= 1'b1;
      end
    end
  end

  assign busy_o = running;

endmodule

// >>> pms_sequencer.sv
//
// Behaviour
// - A move starts at the starting speed and ramps up to operating speed.
// - Operating speed is held, then decel brings the motor to rest on target.
// - One move may travel up to 2,147,483,647 steps either way.
// - A move whose travel leaves that range, or whose target leaves the signed 32-bit range, raises an alarm.
// - A positive travel drives the motor forward.
// - A negative travel drives the motor in reverse.
// - A negative operating speed is used by its magnitude.
// - Absolute type: the position is a target measured from home.
// - Incremental command type: target is command position plus position.
// - Incremental feedback type: target is feedback position plus position.
// - Wrap absolute type: the position is a target inside the wrap range.
// - An accepted start drops ready and starts the selected move.
// - Ready returns high once the move has finished.
// - The eight select inputs form a binary number 0..255, input 0 the LSB.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module pms_sequencer
  import pms_pkg::*;
#(
  parameter int TICK_CYC = RAMP_TICK_CYC
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic [SEL_W-1:0]  data_number_select_inputs_i,
  input  wire logic              start_i,
  input  wire logic [31:0]       feedback_pos_i,
  output logic                   ready_o,
  output logic                   step_o,
  output logic                   dir_o,
  output logic                   moving_o,
  output logic                   alarm_o
);

  // ----------------------------------------------------------------------
  // pin synchronisers: three stages, a change counts when 2nd and 3rd agree
  // ----------------------------------------------------------------------
  localparam int PINS = SEL_W + 1;

  wire  [PINS-1:0] pin_raw = {start_i, data_number_select_inputs_i};
  logic [PINS-1:0] pin_s1_reg;
  logic [PINS-1:0] pin_s2_reg;
  logic [PINS-1:0] pin_s3_reg;
  logic [PINS-1:0] pin_val_reg;

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          pin_s1_reg[gi]  <= 1'b0;
          pin_s2_reg[gi]  <= 1'b0;
          pin_s3_reg[gi]  <= 1'b0;
          pin_val_reg[gi] <= 1'b0;
        end else begin
          pin_s1_reg[gi] <= pin_raw[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
          pin_s3_reg[gi] <= pin_s2_reg[gi];
          if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
            pin_val_reg[gi] <= pin_s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  wire [SEL_W-1:0] sel_num   = pin_val_reg[SEL_W-1:0];
  wire             start_lvl = pin_val_reg[SEL_W];

  // ----------------------------------------------------------------------
  // operation data table and bus decode
  // ----------------------------------------------------------------------
  logic [31:0] pos_mem  [ENTRIES];
  logic [31:0] spd_mem  [ENTRIES];
  logic [1:0]  type_mem [ENTRIES];

  wire [2:0] fld     = addr_i[ADDR_W-1:FLD_LSB];
  wire [7:0] idx     = addr_i[FLD_LSB-1:0];
  wire       is_glb  = (fld == FLD_GLOBAL);
  wire       wr_pos  = wr_i && (fld == FLD_POS);
  wire       wr_spd  = wr_i && (fld == FLD_SPD);
  wire       wr_type = wr_i && (fld == FLD_TYPE);
  wire       wr_glb  = wr_i && is_glb;

  always_ff @(posedge clock_i) begin
    if (wr_pos) begin
      pos_mem[idx] <= wdata_i;
    end
    if (wr_spd) begin
      spd_mem[idx] <= wdata_i;
    end
    if (wr_type) begin
      type_mem[idx] <= wdata_i[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH = 3'b001,
    S_CHECK = 3'b010,
    S_RUN   = 3'b011,
    S_DONE  = 3'b100
  } pms_state_e;

  pms_state_e  state_reg;
  pms_state_e  state_next;
  logic [31:0] start_spd_reg;
  logic [31:0] accel_reg;
  logic [31:0] wrap_range_reg;
  logic [31:0] cmd_pos_reg;
  logic [31:0] wrap_pos_reg;
  logic [31:0] op_pos_reg;
  logic [31:0] op_spd_reg;
  logic [1:0]  op_type_reg;
  logic [31:0] fb_snap_reg;
  logic [31:0] steps_reg;
  logic [31:0] v_run_reg;
  logic        start_prev_reg;
  logic        ready_reg;
  logic        dir_reg;
  logic        alarm_reg;
  logic        go_reg;
  logic        step_reg;
  logic        moving_reg;
  logic [31:0] rdata_reg;

  wire prof_step;
  wire prof_busy;
  wire prof_done;

  wire start_rise = start_lvl && !start_prev_reg;
  wire idle       = (state_reg == S_IDLE);

  // ----------------------------------------------------------------------
  // target and travel, 34 bits so no sum can wrap before it is checked
  // ----------------------------------------------------------------------
  wire [33:0] pos_x  = {{2{op_pos_reg[31]}}, op_pos_reg};
  wire [33:0] cmd_x  = {{2{cmd_pos_reg[31]}}, cmd_pos_reg};
  wire [33:0] fb_x   = {{2{fb_snap_reg[31]}}, fb_snap_reg};
  wire [33:0] wrp_x  = {2'b00, wrap_pos_reg};
  wire [33:0] rng_x  = {2'b00, wrap_range_reg};
  wire        is_wrp = (op_type_reg == PMS_WRAP_ABS);

  logic [33:0] target;
  always_comb begin
    case (op_type_reg)
      PMS_ABS:      target = pos_x;
      PMS_INC_CMD:  target = cmd_x + pos_x;
      PMS_INC_FB:   target = fb_x + pos_x;
      PMS_WRAP_ABS: target = pos_x;
      default:      target = pos_x;
    endcase
  end

  wire [33:0] base     = is_wrp ? wrp_x : cmd_x;
  wire [33:0] travel   = target - base;
  wire        trav_neg = travel[33];
  wire [33:0] trav_mag = trav_neg ? (34'h0 - travel) : travel;
  wire        tgt_fits = (target[33:31] == 3'b000)
                      || (target[33:31] == 3'b111);
  wire        wrap_bad = is_wrp && (pos_x[33] || (pos_x >= rng_x));
  wire        trav_bad = (trav_mag > {2'b00, MAX_TRAVEL});
  wire        move_err = !tgt_fits || trav_bad || wrap_bad;

  // a zero speed entry would never reach the target, so floor at start
  wire [31:0] spd_abs  = op_spd_reg[31] ? (32'h0 - op_spd_reg)
                                       : op_spd_reg;
  wire [31:0] v_run    = (spd_abs < start_spd_reg) ? start_spd_reg
                                                   : spd_abs;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (start_rise) begin
          state_next = S_FETCH;
        end
      end
      S_FETCH: state_next = S_CHECK;
      S_CHECK: state_next = move_err ? S_DONE : S_RUN;
      S_RUN: begin
        if (prof_done) begin
          state_next = S_DONE;
        end
      end
      S_DONE:  state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // handshake and move setup
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg      <= S_IDLE;
      start_prev_reg <= 1'b0;
      ready_reg      <= 1'b0;
      op_pos_reg     <= 32'h0000_0000;
      op_spd_reg     <= 32'h0000_0000;
      op_type_reg    <= PMS_ABS;
      fb_snap_reg    <= 32'h0000_0000;
      steps_reg      <= 32'h0000_0000;
      v_run_reg      <= 32'h0000_0000;
      dir_reg        <= 1'b0;
      go_reg         <= 1'b0;
    end else begin
      state_reg      <= state_next;
      start_prev_reg <= start_lvl;
      go_reg         <= 1'b0;
      // a start held over from the last move waits for a fresh edge
      ready_reg      <= (state_next == S_IDLE);
      if (state_reg == S_IDLE && start_rise) begin
        op_pos_reg  <= pos_mem[sel_num];
        op_spd_reg  <= spd_mem[sel_num];
        op_type_reg <= type_mem[sel_num];
      end
      if (state_reg == S_FETCH) begin
        fb_snap_reg <= feedback_pos_i;
      end
      if (state_reg == S_CHECK && !move_err) begin
        steps_reg <= trav_mag[31:0];
        v_run_reg <= v_run;
        dir_reg   <= !trav_neg;
        go_reg    <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // positions, settings and alarm
  // ----------------------------------------------------------------------
  wire [31:0] wrap_last = wrap_range_reg - 32'h0000_0001;
  wire        st_wr     = wr_glb && (idx == REG_STATUS);
  wire        alarm_set = (state_reg == S_CHECK) && move_err;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      start_spd_reg  <= START_SPD_RST;
      accel_reg      <= ACCEL_RST;
      wrap_range_reg <= WRAP_RANGE_RST;
      cmd_pos_reg    <= 32'h0000_0000;
      wrap_pos_reg   <= 32'h0000_0000;
      alarm_reg      <= 1'b0;
    end else begin
      if (alarm_set) begin
        alarm_reg <= 1'b1;
      end else if (st_wr && wdata_i[ST_ALARM]) begin
        alarm_reg <= 1'b0;
      end
      if (prof_step) begin
        cmd_pos_reg <= dir_reg ? cmd_pos_reg + 32'h1
                               : cmd_pos_reg - 32'h1;
        if (dir_reg) begin
          wrap_pos_reg <= (wrap_pos_reg >= wrap_last) ? 32'h0
                        : wrap_pos_reg + 32'h1;
        end else begin
          wrap_pos_reg <= (wrap_pos_reg == 32'h0) ? wrap_last
                        : wrap_pos_reg - 32'h1;
        end
      end else if (wr_glb && idle) begin
        case (idx)
          REG_START_SPD:  start_spd_reg  <= wdata_i;
          REG_ACCEL:      accel_reg      <= wdata_i;
          REG_WRAP_RANGE: wrap_range_reg <= wdata_i;
          REG_CMD_POS:    cmd_pos_reg    <= wdata_i;
          REG_WRAP_POS:   wrap_pos_reg   <= wdata_i;
          default:        cmd_pos_reg    <= cmd_pos_reg;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // speed profile and step generation
  // ----------------------------------------------------------------------
  pms_profile #(
    .TICK_CYC (TICK_CYC)
  ) u_profile (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .go_i      (go_reg),
    .steps_i   (steps_reg),
    .v_start_i (start_spd_reg),
    .v_run_i   (v_run_reg),
    .accel_i   (accel_reg),
    .step_o    (prof_step),
    .busy_o    (prof_busy),
    .done_o    (prof_done)
  );

  // ----------------------------------------------------------------------
  // read port: data one cycle after the strobe, zero elsewhere
  // ----------------------------------------------------------------------
  wire [31:0] status_w = {29'h0, alarm_reg, moving_reg, ready_reg};

  logic [31:0] glb_rd;
  always_comb begin
    case (idx)
      REG_START_SPD:  glb_rd = start_spd_reg;
      REG_ACCEL:      glb_rd = accel_reg;
      REG_WRAP_RANGE: glb_rd = wrap_range_reg;
      REG_CMD_POS:    glb_rd = cmd_pos_reg;
      REG_STATUS:     glb_rd = status_w;
      REG_WRAP_POS:   glb_rd = wrap_pos_reg;
      default:        glb_rd = 32'h0000_0000;
    endcase
  end

  logic [31:0] rd_mux;
  always_comb begin
    case (fld)
      FLD_POS:    rd_mux = pos_mem[idx];
      FLD_SPD:    rd_mux = spd_mem[idx];
      FLD_TYPE:   rd_mux = {30'h0, type_mem[idx]};
      FLD_GLOBAL: rd_mux = glb_rd;
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_reg  <= 32'h0000_0000;
      step_reg   <= 1'b0;
      moving_reg <= 1'b0;
    end else begin
      rdata_reg  <= rd_i ? rd_mux : 32'h0000_0000;
      step_reg   <= prof_step;
      moving_reg <= prof_busy;
    end
  end

  assign rdata_o  = rdata_reg;
  assign ready_o  = ready_reg;
  assign step_o   = step_reg;
  assign dir_o    = dir_reg;
  assign moving_o = moving_reg;
  assign alarm_o  = alarm_reg;

endmodule

// >>> pms_sequencer_checker.sv
`timescale 1ns/1ns
module pms_sequencer_checker (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic start_i,
  input wire logic ready_o,
  input wire logic step_o,
  input wire logic dir_o,
  input wire logic moving_o,
  input wire logic alarm_o
);
  // ------------------------------------------------------------------
  // handshake and motion properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  sequence s_accept;
    $rose(start_i) && ready_o;
  endsequence
  // pin filter plus start edge detect before ready drops on entering fetch
  sequence s_drop;
    ##[3:8] !ready_o;
  endsequence
  sequence s_reject;
    !moving_o ##[1:2] ready_o;
  endsequence
  property p_accept;
    s_accept |-> s_drop;
  endproperty
  a_accept: assert property (p_accept) else $error("start ignored");
  property p_busy;
    moving_o |-> !ready_o;
  endproperty
  a_busy: assert property (p_busy) else $error("ready while moving");
  property p_done;
    $fell(moving_o) |-> ##[0:4] ready_o;
  endproperty
  a_done: assert property (p_done) else $error("ready late");
  property p_step_busy;
    step_o |-> !ready_o;
  endproperty
  a_step_busy: assert property (p_step_busy) else $error("idle step");
  property p_dir;
    step_o |-> $stable(dir_o);
  endproperty
  a_dir: assert property (p_dir) else $error("dir moved at step");
  property p_dir_hold;
    moving_o && $past(moving_o) |-> $stable(dir_o);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("dir moved");
  property p_sticky;
    alarm_o && !wr_i |=> alarm_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("alarm lost");
  property p_reject;
    $rose(alarm_o) |-> s_reject;
  endproperty
  a_reject: assert property (p_reject) else $error("bad alarm end");
endmodule

bind pms_sequencer pms_sequencer_checker u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .wr_i(wr_i), .start_i(start_i),
  .ready_o(ready_o), .step_o(step_o), .dir_o(dir_o),
  .moving_o(moving_o), .alarm_o(alarm_o)
);

// >>> pms_host_model.sv
`timescale 1ns/1ns
module pms_host_model
  import pms_pkg::*;
(
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             go_i,
  input  wire logic [SEL_W-1:0] num_i,
  input  wire logic [7:0]       hold_i,
  input  wire logic             ready_i,
  output logic                  start_o,
  output logic      [SEL_W-1:0] sel_o,
  output logic                  busy_o
);
  // ------------------------------------------------------------------
  // start handshake, hold_i stretches start to act as a slow host
  // ------------------------------------------------------------------
  logic [7:0] cnt_reg;
  logic [1:0] ph_reg;
  always @(posedge clock_i) begin
    if (rst_i) begin
      ph_reg  <= 2'h0;
      cnt_reg <= 8'h00;
      start_o <= 1'b0;
      sel_o   <= 8'h00;
      busy_o  <= 1'b0;
    end else begin
      case (ph_reg)
        2'h0: if (go_i && ready_i) begin
          sel_o   <= num_i;
          cnt_reg <= 8'h05;
          busy_o  <= 1'b1;
          ph_reg  <= 2'h1;
        end
        // the pins are filtered, so the number settles before start
        2'h1: if (cnt_reg == 8'h00) begin
          start_o <= 1'b1;
          ph_reg  <= 2'h2;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
        2'h2: if (!ready_i) begin
          cnt_reg <= hold_i;
          ph_reg  <= 2'h3;
        end
        default: if (cnt_reg == 8'h00) begin
          start_o <= 1'b0;
          sel_o   <= ~sel_o;
          busy_o  <= 1'b0;
          ph_reg  <= 2'h0;
        end else begin
          cnt_reg <= cnt_reg - 8'h01;
        end
      endcase
    end
  end
endmodule

// >>> pms_sequencer_tb_top.sv
`timescale 1ns/1ns
module pms_sequencer_tb_top;
  import pms_pkg::*;
  localparam logic [10:0] A_CMD = {FLD_GLOBAL, REG_CMD_POS};
  localparam logic [10:0] A_ST  = {FLD_GLOBAL, REG_STATUS};
  localparam logic [10:0] A_WR  = {FLD_GLOBAL, REG_WRAP_POS};
  localparam logic [31:0] SPD   = 32'h004c_4b40;
  logic              clock_i = 1'b0;
  logic              rst_i   = 1'b1;
  logic [ADDR_W-1:0] addr    = '0;
  logic [DATA_W-1:0] wdata   = '0;
  logic              wr_s    = 1'b0;
  logic              rd_s    = 1'b0;
  logic              go      = 1'b0;
  logic [7:0]        num     = '0;
  logic [7:0]        hold    = '0;
  logic [31:0]       fb      = '0;
  logic [31:0]       rdata;
  logic [7:0]        sel;
  logic              start, ready, step, dir, moving, alarm, hbusy;
  int                n_fail   = 0;
  int                n_checks = 0;
  int                g0, g1, gl;
  always #5 clock_i = ~clock_i;
  pms_sequencer #(.TICK_CYC(20)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata),
    .data_number_select_inputs_i(sel), .start_i(start),
    .feedback_pos_i(fb), .ready_o(ready), .step_o(step), .dir_o(dir),
    .moving_o(moving), .alarm_o(alarm)
  );
  pms_host_model host (
    .clock_i(clock_i), .rst_i(rst_i), .go_i(go), .num_i(num),
    .hold_i(hold), .ready_i(ready), .start_o(start), .sel_o(sel),
    .busy_o(hbusy)
  );
  // ------------------------------------------------------------------
  // bus, compare and move tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clock_i);
    wr_s  <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [10:0] a, input logic [31:0] e,
                    input string nm);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    @(negedge clock_i);
    chk(nm, e, rdata);
    @(posedge clock_i);
  endtask
  task automatic setup(input logic [7:0] i, input pms_optype_e t,
                       input logic [31:0] p, input logic [31:0] s);
    wr({FLD_POS, i}, p);
    wr({FLD_SPD, i}, s);
    wr({FLD_TYPE, i}, {30'h0, t});
  endtask
  // g1 first gap, g0 shortest gap, gl last gap, in cycles
  task automatic run_move(input logic [7:0] n, input int ns,
                          input logic d, input logic a);
    int k;
    int c;
    int t;
    logic mv;
    c  = 0;
    t  = 0;
    mv = 1'b0;
    g0 = 99999;
    num <= n;
    go  <= 1'b1;
    @(posedge clock_i);
    go  <= 1'b0;
    for (k = 0; k < 20000; k++) begin
      @(negedge clock_i);
      if (moving === 1'b1) mv = 1'b1;
      if (step === 1'b1) begin
        chk("dir", {31'h0, d}, {31'h0, dir});
        if (c == 1) g1 = k - t;
        if (c > 0 && k - t < g0) g0 = k - t;
        gl = k - t;
        t  = k;
        c++;
      end
      if (k > 2 && ready === 1'b1 && hbusy === 1'b0) break;
    end
    if (k == 20000) begin
      $display("ERROR move expected done seen busy");
      n_fail++;
      close_out();
    end
    chk("steps", 32'(ns), 32'(c));
    chk("alarm", {31'h0, a}, {31'h0, alarm});
    chk("moving", {31'h0, ~a}, {31'h0, mv});
    repeat (10) @(negedge clock_i);
    chk("ready", 32'h1, {31'h0, ready});
    @(posedge clock_i);
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] ev [6] = '{START_SPD_RST, ACCEL_RST, WRAP_RANGE_RST,
                            32'h0, 32'h1, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rd({FLD_GLOBAL, 8'(i)}, ev[i], "global");
    end
    wr(11'h700, 32'hffff_ffff);
    rd(11'h700, 32'h0, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_abs();
    setup(8'h01, PMS_ABS, 32'h28, SPD);
    run_move(8'h01, 40, 1'b1, 1'b0);
    chk("accel", 32'h1, {31'h0, g1 > g0});
    chk("decel", 32'h1, {31'h0, gl > g0});
    rd(A_CMD, 32'h28, "cmd_pos");
    $display("test abs done");
  endtask
  task automatic t_inc_cmd();
    setup(8'hfe, PMS_INC_CMD, 32'hffff_fff1, 32'hffb3_b4c0);
    run_move(8'hfe, 15, 1'b0, 1'b0);
    chk("peak", 32'(CLK_HZ) / SPD, 32'(g0));
    rd(A_CMD, 32'h19, "cmd_pos");
    $display("test inc_cmd done");
  endtask
  task automatic t_inc_fb();
    fb   <= 32'h64;
    hold <= 8'hff;
    setup(8'h80, PMS_INC_FB, 32'hffff_ffba, SPD);
    run_move(8'h80, 5, 1'b1, 1'b0);
    rd(A_CMD, 32'h1e, "cmd_pos");
    hold <= 8'h00;
    $display("test inc_fb done");
  endtask
  task automatic t_wrap();
    wr(A_WR, 32'h0);
    setup(8'hff, PMS_WRAP_ABS, 32'ha, SPD);
    run_move(8'hff, 10, 1'b1, 1'b0);
    rd(A_WR, 32'ha, "wrap_pos");
    $display("test wrap done");
  endtask
  task automatic t_alarm();
    wr(A_CMD, 32'hffff_ffff);
    setup(8'h02, PMS_ABS, 32'h7fff_ffff, SPD);
    run_move(8'h02, 0, 1'b1, 1'b1);
    rd(A_ST, 32'h5, "status");
    rd(A_CMD, 32'hffff_ffff, "cmd_pos");
    wr(A_ST, 32'h4);
    rd(A_ST, 32'h1, "status");
    setup(8'h03, PMS_WRAP_ABS, WRAP_RANGE_RST, SPD);
    run_move(8'h03, 0, 1'b1, 1'b1);
    wr(A_ST, 32'h4);
    $display("test alarm done");
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    t_regs();
    // faster ramp so moves stay short in simulation
    wr({FLD_GLOBAL, REG_START_SPD}, 32'h000f_4240);
    wr({FLD_GLOBAL, REG_ACCEL}, 32'h000f_4240);
    t_abs();
    t_inc_cmd();
    t_inc_fb();
    t_wrap();
    t_alarm();
    close_out();
  end
endmodule
